// ---- hdl/ubr_register_bank.sv ----
// Register bank of the serial bridge, reached by decoded vendor requests
`timescale 1ns/10ps
`default_nettype none
module ubr_register_bank #(
   parameter logic [15:0] REVISION_VALUE = 16'h0001 // Arbitrary value
) (
   input  wire logic                clk,
   input  wire logic                reset,
   input  wire logic                req_valid,
   input  wire ubr_pkg::ubr_req_s   req,
   input  wire ubr_pkg::ubr_line_s  line,
   output logic                     resp_valid,
   output logic                     resp_stall,
   output logic [15:0]              resp_data,
   output ubr_pkg::ubr_words_t      cfg_words,
   output logic [9:0]               pin_out,
   output logic                     tx_enable,
   output logic                     rx_enable,
   output logic [2:0]               flow_mode
);

   ubr_pkg::ubr_words_t words_q;
   ubr_pkg::ubr_words_t words_d;
   logic [9:0]          pin_out_q;
   logic [9:0]          pin_out_d;
   logic                resp_valid_q;
   logic                resp_valid_d;
   logic                resp_stall_q;
   logic                resp_stall_d;
   logic [15:0]         resp_data_q;
   logic [15:0]         resp_data_d;

   logic                is_gen_wr;
   logic                is_gen_rd;
   logic                is_rev_rd;
   logic                is_stat_wr;
   logic                is_stat_rd;
   logic [4:0]          map_slot;
   logic                map_rw;
   logic                map_ro;
   logic                map_wo;
   logic [15:0]         ro_data;
   logic [15:0]         wr_word;
   logic                accepted;
   logic                err_clear;
   logic [3:0]          err_set;
   logic [3:0]          err_flags;

   // Offset to storage slot; the revision and bus-status words are absent
   function automatic logic [4:0] slot_of(input logic [15:0] idx);
      logic [4:0] s;
      s = ubr_pkg::SLOT_NONE;
      case (idx)
         ubr_pkg::OFF_PORT_ENABLE:  s = ubr_pkg::SLOT_PORT_ENABLE;
         ubr_pkg::OFF_HANDSHAKE:    s = ubr_pkg::SLOT_HANDSHAKE;
         ubr_pkg::OFF_RESUME_CHAR:  s = ubr_pkg::SLOT_RESUME_CHAR;
         ubr_pkg::OFF_PAUSE_CHAR:   s = ubr_pkg::SLOT_PAUSE_CHAR;
         ubr_pkg::OFF_BREAK_DUR:    s = ubr_pkg::SLOT_BREAK_DUR;
         ubr_pkg::OFF_XCVR_DELAY:   s = ubr_pkg::SLOT_XCVR_DELAY;
         ubr_pkg::OFF_PIN_FUNC:     s = ubr_pkg::SLOT_PIN_FUNC;
         ubr_pkg::OFF_PIN_DIR:      s = ubr_pkg::SLOT_PIN_DIR;
         ubr_pkg::OFF_PIN_EVT_MASK: s = ubr_pkg::SLOT_PIN_EVT_MASK;
         ubr_pkg::OFF_CUSTOM_EVT:   s = ubr_pkg::SLOT_CUSTOM_EVT;
         ubr_pkg::OFF_PIN_DRAIN:    s = ubr_pkg::SLOT_PIN_DRAIN;
         ubr_pkg::OFF_PULL_HIGH:    s = ubr_pkg::SLOT_PULL_HIGH;
         ubr_pkg::OFF_PULL_LOW:     s = ubr_pkg::SLOT_PULL_LOW;
         ubr_pkg::OFF_WRAP_TEST:    s = ubr_pkg::SLOT_WRAP_TEST;
         ubr_pkg::OFF_INFRARED:     s = ubr_pkg::SLOT_INFRARED;
         ubr_pkg::OFF_CLK_DIV:      s = ubr_pkg::SLOT_CLK_DIV;
         ubr_pkg::OFF_WAKE:         s = ubr_pkg::SLOT_WAKE;
         ubr_pkg::OFF_TX_PURGE:     s = ubr_pkg::SLOT_TX_PURGE;
         ubr_pkg::OFF_TX_WIDE:      s = ubr_pkg::SLOT_TX_WIDE;
         ubr_pkg::OFF_RX_PURGE:     s = ubr_pkg::SLOT_RX_PURGE;
         ubr_pkg::OFF_RX_WIDE:      s = ubr_pkg::SLOT_RX_WIDE;
         ubr_pkg::OFF_FAST_RESP:    s = ubr_pkg::SLOT_FAST_RESP;
         ubr_pkg::OFF_RX_TRIGGER:   s = ubr_pkg::SLOT_RX_TRIGGER;
         ubr_pkg::OFF_VENDOR_DRV:   s = ubr_pkg::SLOT_VENDOR_DRV;
         ubr_pkg::OFF_SLEEP_LEVELS: s = ubr_pkg::SLOT_SLEEP_LEVELS;
         ubr_pkg::OFF_SLEEP_DRIVE:  s = ubr_pkg::SLOT_SLEEP_DRIVE;
         default:                   s = ubr_pkg::SLOT_NONE;
      endcase
      return s;
   endfunction

   // Request classification
   always_comb begin
      is_gen_wr  = req.rtype == ubr_pkg::RT_IF_OUT && req.code == ubr_pkg::REQ_CODE_REG;
      is_gen_rd  = req.rtype == ubr_pkg::RT_IF_IN && req.code == ubr_pkg::REQ_CODE_REG;
      is_rev_rd  = req.rtype == ubr_pkg::RT_DEV_IN && req.code == ubr_pkg::REQ_CODE_REG
                   && req.index == ubr_pkg::OFF_REVISION;
      is_stat_wr = req.rtype == ubr_pkg::RT_DEV_OUT && req.code == ubr_pkg::REQ_CODE_REG
                   && req.index == ubr_pkg::OFF_BUS_STATUS;
      is_stat_rd = req.rtype == ubr_pkg::RT_DEV_IN && req.code == ubr_pkg::REQ_CODE_REG
                   && req.index == ubr_pkg::OFF_BUS_STATUS;
   end

   // Generic index decode; read-only words come from the line inputs
   always_comb begin
      map_slot = slot_of(req.index);
      map_rw   = map_slot != ubr_pkg::SLOT_NONE;
      map_ro   = 1'b0;
      map_wo   = 1'b0;
      ro_data  = '0;
      case (req.index)
         ubr_pkg::OFF_LINE_ERR: begin
            map_ro  = 1'b1;
            ro_data = {8'h00, line.break_now, err_flags, 3'h0};
         end
         ubr_pkg::OFF_PIN_LEVEL: begin
            map_ro  = 1'b1;
            ro_data = {4'h0, line.pin_in} & ubr_pkg::PIN_LVL_MASK;
         end
         ubr_pkg::OFF_TX_LEVEL: begin
            map_ro  = 1'b1;
            ro_data = {6'h00, line.tx_level};
         end
         ubr_pkg::OFF_RX_LEVEL: begin
            map_ro  = 1'b1;
            ro_data = {6'h00, line.rx_level};
         end
         ubr_pkg::OFF_PIN_SET,
         ubr_pkg::OFF_PIN_CLR: begin
            map_wo = 1'b1;
         end
         default: begin
            map_ro = 1'b0;
         end
      endcase
   end

   // Masked write word; a reserved mode code leaves the old mode standing
   always_comb begin
      wr_word = '0;
      if (map_rw) begin
         wr_word = req.value & ubr_pkg::SLOT_MASK[map_slot];
      end
      if (map_slot == ubr_pkg::SLOT_HANDSHAKE && req.value[2:0] > ubr_pkg::FLOW_DROP_ALL) begin
         wr_word[2:0] = words_q[ubr_pkg::SLOT_HANDSHAKE][2:0];
      end
   end

   // Storage and pin output latch
   always_comb begin
      words_d   = words_q;
      pin_out_d = pin_out_q;
      if (req_valid && is_gen_wr && map_rw) begin
         words_d[map_slot] = wr_word;
      end
      if (req_valid && is_stat_wr) begin
         words_d[ubr_pkg::SLOT_BUS_STATUS] = req.value & ubr_pkg::SLOT_MASK[ubr_pkg::SLOT_BUS_STATUS];
      end
      // Set and clear words act on the latch without ever reading back
      if (req_valid && is_gen_wr && req.index == ubr_pkg::OFF_PIN_SET) begin
         pin_out_d = pin_out_q | req.value[9:0];
      end
      if (req_valid && is_gen_wr && req.index == ubr_pkg::OFF_PIN_CLR) begin
         pin_out_d = pin_out_q & ~req.value[9:0];
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         words_q   <= ubr_pkg::RST_WORDS;
         pin_out_q <= '0;
      end else begin
         words_q   <= words_d;
         pin_out_q <= pin_out_d;
      end
   end

   // Error history; the reading request clears what it returned
   always_comb begin
      err_set   = {line.overrun_evt, line.parity_evt, line.framing_evt, line.break_evt};
      err_clear = req_valid && is_gen_rd && req.index == ubr_pkg::OFF_LINE_ERR;
   end

   ubr_sticky_flags #(
      .WIDTH (4)
   ) u_err_flags (
      .clk   (clk),
      .reset (reset),
      .set   (err_set),
      .clear (err_clear),
      .flags (err_flags)
   );

   // Answer path: one cycle after each request, stall when nothing matches
   always_comb begin
      accepted     = ((is_gen_wr || is_gen_rd) && (map_rw || map_ro || map_wo))
                     || is_rev_rd || is_stat_wr || is_stat_rd;
      resp_valid_d = req_valid;
      resp_stall_d = req_valid && !accepted;
      resp_data_d  = '0;
      if (req_valid && is_gen_rd && map_rw) begin
         resp_data_d = words_q[map_slot];
      end else if (req_valid && is_gen_rd && map_ro) begin
         resp_data_d = ro_data;
      end else if (req_valid && is_rev_rd) begin
         resp_data_d = REVISION_VALUE;
      end else if (req_valid && is_stat_rd) begin
         resp_data_d = words_q[ubr_pkg::SLOT_BUS_STATUS];
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         resp_valid_q <= 1'b0;
         resp_stall_q <= 1'b0;
         resp_data_q  <= '0;
      end else begin
         resp_valid_q <= resp_valid_d;
         resp_stall_q <= resp_stall_d;
         resp_data_q  <= resp_data_d;
      end
   end

   assign resp_valid = resp_valid_q;
   assign resp_stall = resp_stall_q;
   assign resp_data  = resp_data_q;
   assign cfg_words  = words_q;
   assign pin_out    = pin_out_q;
   // Host is trusted to hold these low around other writes
   assign tx_enable  = words_q[ubr_pkg::SLOT_PORT_ENABLE][ubr_pkg::PE_TX_BIT];
   assign rx_enable  = words_q[ubr_pkg::SLOT_PORT_ENABLE][ubr_pkg::PE_RX_BIT];
   assign flow_mode  = words_q[ubr_pkg::SLOT_HANDSHAKE][2:0];

   default clocking @(posedge clk);
   endclocking
   default disable iff (reset);

   logic gen_rd_rev;
   logic gen_wr_stat;
   assign gen_rd_rev  = req_valid && is_gen_rd && req.index == ubr_pkg::OFF_REVISION;
   assign gen_wr_stat = req_valid && is_gen_wr && req.index == ubr_pkg::OFF_BUS_STATUS;

   answer_follows_a: assert property (
      req_valid |=> resp_valid ##1 !resp_valid || $past(req_valid))
      else $error("request got no answer next cycle");

   rev_generic_a: assert property (
      gen_rd_rev |=> resp_stall && resp_data == 16'h0000)
      else $error("generic read reached the revision word");

   rev_read_a: assert property (
      req_valid && is_rev_rd |=> !resp_stall && resp_data == REVISION_VALUE)
      else $error("revision request returned wrong word");

   stat_generic_a: assert property (
      gen_wr_stat |=> resp_stall && $stable(words_q[ubr_pkg::SLOT_BUS_STATUS]))
      else $error("generic write reached the bus-status word");

   stat_write_a: assert property (
      req_valid && is_stat_wr
      |=> words_q[ubr_pkg::SLOT_BUS_STATUS] == ($past(req.value) & ubr_pkg::SLOT_MASK[ubr_pkg::SLOT_BUS_STATUS]))
      else $error("bus-status write not stored");

   word_store_a: assert property (
      req_valid && is_gen_wr && req.index == ubr_pkg::OFF_BREAK_DUR
      |=> words_q[ubr_pkg::SLOT_BREAK_DUR] == $past(req.value))
      else $error("break duration word not stored whole");

   reserved_zero_a: assert property (
      req_valid && is_gen_rd && req.index == ubr_pkg::OFF_RESUME_CHAR
      |=> resp_data[15:8] == 8'h00 && resp_data[7:0] == $past(words_q[ubr_pkg::SLOT_RESUME_CHAR][7:0]))
      else $error("reserved bits took a value");

   port_enable_a: assert property (
      req_valid && is_gen_wr && req.index == ubr_pkg::OFF_PORT_ENABLE
      |=> tx_enable == $past(req.value[0]) && rx_enable == $past(req.value[1]))
      else $error("port enable bits misplaced");

   flow_reserved_a: assert property (
      req_valid && is_gen_wr && req.index == ubr_pkg::OFF_HANDSHAKE && req.value[2:0] > ubr_pkg::FLOW_DROP_ALL
      |=> flow_mode == $past(flow_mode))
      else $error("reserved mode code was taken");

   err_clear_a: assert property (
      err_clear && err_set == 4'h0 |=> err_flags == 4'h0 && resp_data[6:3] == $past(err_flags))
      else $error("error flags survived their read");

   err_set_wins_a: assert property (
      line.overrun_evt |=> err_flags[3])
      else $error("overrun event lost");

   level_read_a: assert property (
      req_valid && is_gen_rd && req.index == ubr_pkg::OFF_TX_LEVEL
      |=> !resp_stall && resp_data == {6'h00, $past(line.tx_level)})
      else $error("transmit level read wrong");

   gen_write_cov: cover property (req_valid && is_gen_wr && map_rw ##1 resp_valid && !resp_stall);
   err_read_cov: cover property (err_flags != 4'h0 ##1 err_clear);
   stat_rw_cov: cover property (req_valid && is_stat_wr ##2 req_valid && is_stat_rd);
   stall_cov: cover property (resp_stall);

endmodule
`default_nettype wire

// ---- hdl/ubr_sticky_flags.sv ----
// Sticky event flags with a shared clear, set winning over clear
`timescale 1ns/10ps
`default_nettype none
module ubr_sticky_flags #(
   parameter int WIDTH = 4
) (
   input  wire logic             clk,
   input  wire logic             reset,
   input  wire logic [WIDTH-1:0] set,
   input  wire logic             clear,
   output logic      [WIDTH-1:0] flags
);

   logic [WIDTH-1:0] flags_q;
   logic [WIDTH-1:0] flags_d;

   // An event in the clearing cycle survives the clear
   always_comb begin
      flags_d = (flags_q & ~{WIDTH{clear}}) | set;
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         flags_q <= '0;
      end else begin
         flags_q <= flags_d;
      end
   end

   assign flags = flags_q;

endmodule
`default_nettype wire

// ---- inc/ubr_pkg.sv ----
// Constants, types and tables shared by the bridge register bank
`default_nettype none
package ubr_pkg;

   localparam logic [7:0]  RT_DEV_OUT = 8'h40;
   localparam logic [7:0]  RT_DEV_IN  = 8'hC0;
   localparam logic [7:0]  RT_IF_OUT  = 8'h41;
   localparam logic [7:0]  RT_IF_IN   = 8'hC1;
   localparam logic [7:0]  REQ_CODE_REG = 8'h00;

   localparam logic [15:0] OFF_PORT_ENABLE    = 16'h0000;
   localparam logic [15:0] OFF_HANDSHAKE      = 16'h0006;
   localparam logic [15:0] OFF_RESUME_CHAR    = 16'h0007;
   localparam logic [15:0] OFF_PAUSE_CHAR     = 16'h0008;
   localparam logic [15:0] OFF_LINE_ERR       = 16'h0009;
   localparam logic [15:0] OFF_BREAK_DUR      = 16'h000A;
   localparam logic [15:0] OFF_XCVR_DELAY     = 16'h000B;
   localparam logic [15:0] OFF_PIN_FUNC       = 16'h000C;
   localparam logic [15:0] OFF_PIN_DIR        = 16'h000D;
   localparam logic [15:0] OFF_PIN_SET        = 16'h000E;
   localparam logic [15:0] OFF_PIN_CLR        = 16'h000F;
   localparam logic [15:0] OFF_PIN_LEVEL      = 16'h0010;
   localparam logic [15:0] OFF_PIN_EVT_MASK   = 16'h0011;
   localparam logic [15:0] OFF_CUSTOM_EVT     = 16'h0012;
   localparam logic [15:0] OFF_PIN_DRAIN      = 16'h0013;
   localparam logic [15:0] OFF_PULL_HIGH      = 16'h0014;
   localparam logic [15:0] OFF_PULL_LOW       = 16'h0015;
   localparam logic [15:0] OFF_WRAP_TEST      = 16'h0016;
   localparam logic [15:0] OFF_INFRARED       = 16'h0017;
   localparam logic [15:0] OFF_CLK_DIV        = 16'h0018;
   localparam logic [15:0] OFF_WAKE           = 16'h001F;
   localparam logic [15:0] OFF_TX_PURGE       = 16'h0040;
   localparam logic [15:0] OFF_TX_LEVEL       = 16'h0041;
   localparam logic [15:0] OFF_TX_WIDE        = 16'h0042;
   localparam logic [15:0] OFF_RX_PURGE       = 16'h0043;
   localparam logic [15:0] OFF_RX_LEVEL       = 16'h0044;
   localparam logic [15:0] OFF_RX_WIDE        = 16'h0045;
   localparam logic [15:0] OFF_FAST_RESP      = 16'h0046;
   localparam logic [15:0] OFF_RX_TRIGGER     = 16'h0047;
   localparam logic [15:0] OFF_VENDOR_DRV     = 16'h0060;
   localparam logic [15:0] OFF_SLEEP_LEVELS   = 16'h006A;
   localparam logic [15:0] OFF_SLEEP_DRIVE    = 16'h006B;
   localparam logic [15:0] OFF_REVISION       = 16'h0260;
   localparam logic [15:0] OFF_BUS_STATUS     = 16'h0262;

   // Storage slots, in the order of the mask table below
   localparam int NUM_SLOTS = 27;
   localparam logic [4:0]  SLOT_PORT_ENABLE  = 5'h00;
   localparam logic [4:0]  SLOT_HANDSHAKE    = 5'h01;
   localparam logic [4:0]  SLOT_RESUME_CHAR  = 5'h02;
   localparam logic [4:0]  SLOT_PAUSE_CHAR   = 5'h03;
   localparam logic [4:0]  SLOT_BREAK_DUR    = 5'h04;
   localparam logic [4:0]  SLOT_XCVR_DELAY   = 5'h05;
   localparam logic [4:0]  SLOT_PIN_FUNC     = 5'h06;
   localparam logic [4:0]  SLOT_PIN_DIR      = 5'h07;
   localparam logic [4:0]  SLOT_PIN_EVT_MASK = 5'h08;
   localparam logic [4:0]  SLOT_CUSTOM_EVT   = 5'h09;
   localparam logic [4:0]  SLOT_PIN_DRAIN    = 5'h0A;
   localparam logic [4:0]  SLOT_PULL_HIGH    = 5'h0B;
   localparam logic [4:0]  SLOT_PULL_LOW     = 5'h0C;
   localparam logic [4:0]  SLOT_WRAP_TEST    = 5'h0D;
   localparam logic [4:0]  SLOT_INFRARED     = 5'h0E;
   localparam logic [4:0]  SLOT_CLK_DIV      = 5'h0F;
   localparam logic [4:0]  SLOT_WAKE         = 5'h10;
   localparam logic [4:0]  SLOT_TX_PURGE     = 5'h11;
   localparam logic [4:0]  SLOT_TX_WIDE      = 5'h12;
   localparam logic [4:0]  SLOT_RX_PURGE     = 5'h13;
   localparam logic [4:0]  SLOT_RX_WIDE      = 5'h14;
   localparam logic [4:0]  SLOT_FAST_RESP    = 5'h15;
   localparam logic [4:0]  SLOT_RX_TRIGGER   = 5'h16;
   localparam logic [4:0]  SLOT_VENDOR_DRV   = 5'h17;
   localparam logic [4:0]  SLOT_SLEEP_LEVELS = 5'h18;
   localparam logic [4:0]  SLOT_SLEEP_DRIVE  = 5'h19;
   localparam logic [4:0]  SLOT_BUS_STATUS   = 5'h1A;
   localparam logic [4:0]  SLOT_NONE         = 5'h1F;

   // Writable bits per slot; everything else is reserved
   localparam logic [15:0] SLOT_MASK [NUM_SLOTS] = '{
      16'h0003, 16'h000F, 16'h00FF, 16'h00FF, 16'hFFFF, 16'h000F, 16'h03FF,
      16'h03FF, 16'h07FF, 16'h0003, 16'h0BFF, 16'h07FF, 16'h07FF, 16'h0007,
      16'h0007, 16'hFFFF, 16'h000C, 16'h0007, 16'h0001, 16'h0007, 16'h0001,
      16'h0001, 16'h03FF, 16'h0001, 16'h3CCF, 16'hBCCF, 16'h3F3F};
   localparam logic [15:0] PIN_MASK      = 16'h03FF;
   localparam logic [15:0] PIN_LVL_MASK  = 16'h0FFF;

   localparam logic [15:0] RST_RESUME_CHAR = 16'h0011;
   localparam logic [15:0] RST_PAUSE_CHAR  = 16'h0013;

   localparam int PE_TX_BIT = 0;
   localparam int PE_RX_BIT = 1;

   localparam logic [2:0]  FLOW_NONE     = 3'h0;
   localparam logic [2:0]  FLOW_HW       = 3'h1;
   localparam logic [2:0]  FLOW_SW       = 3'h2;
   localparam logic [2:0]  FLOW_DROP_RX  = 3'h3;
   localparam logic [2:0]  FLOW_DROP_ALL = 3'h4;

   localparam int ERR_BREAK_NOW = 7;
   localparam int ERR_HIST_LSB  = 3;

   typedef logic [NUM_SLOTS-1:0][15:0] ubr_words_t;

   typedef struct packed {
      logic [7:0]  rtype;
      logic [7:0]  code;
      logic [15:0] value;
      logic [15:0] index;
   } ubr_req_s;

   // Serial line and pin state fed in by the datapath
   typedef struct packed {
      logic        break_now;
      logic        overrun_evt;
      logic        parity_evt;
      logic        framing_evt;
      logic        break_evt;
      logic [11:0] pin_in;
      logic [9:0]  tx_level;
      logic [9:0]  rx_level;
   } ubr_line_s;

   function automatic ubr_words_t rst_words();
      ubr_words_t w;
      w = '0;
      w[SLOT_RESUME_CHAR] = RST_RESUME_CHAR;
      w[SLOT_PAUSE_CHAR] = RST_PAUSE_CHAR;
      return w;
   endfunction

   localparam ubr_words_t RST_WORDS = rst_words();

endpackage
`default_nettype wire

// ---- verification/ubr_host_model.sv ----
// Host model issuing vendor control requests to the register bank
`timescale 1ns/10ps
`default_nettype none
module ubr_host_model (
   input  wire logic         clk,
   input  wire logic         resp_valid,
   input  wire logic         resp_stall,
   input  wire logic [15:0]  resp_data,
   output logic              req_valid,
   output ubr_pkg::ubr_req_s req
);
   initial begin
      req_valid = 1'b0;
      req = '0;
   end
   // One request; the answer stands only in the cycle after the taking edge
   task automatic xfer(input logic [7:0] rtype, input logic [15:0] index, input logic [15:0] value,
                       output logic [15:0] data, output logic stall, output bit got);
      int n;
      got = 1'b0;
      @(negedge clk);
      req_valid = 1'b1;
      req = '{rtype, 8'h00, value, index};
      @(negedge clk);
      req_valid = 1'b0;
      // Released fields must not keep showing the last request
      req = ~req;
      for (n = 0; n < 4 && !got; n++) begin
         if (resp_valid === 1'b1) begin
            got = 1'b1;
            data = resp_data;
            stall = resp_stall;
         end else begin
            @(negedge clk);
         end
      end
   endtask
   // Serial port held off around a configuration write
   task automatic cfg_write(input logic [15:0] index, input logic [15:0] value, output bit got);
      logic [15:0] d;
      logic        s;
      bit          g0;
      bit          g1;
      xfer(8'h41, 16'h0000, 16'h0000, d, s, g0);
      xfer(8'h41, index, value, d, s, got);
      xfer(8'h41, 16'h0000, 16'h0003, d, s, g1);
      got = got & g0 & g1;
   endtask
endmodule
`default_nettype wire

// ---- verification/usb_bridge_register_bank_test.sv ----
// Self-checking bench for the bridge register bank
`timescale 1ns/10ps
`default_nettype none
module usb_bridge_register_bank_test;
   localparam logic [15:0] REV = 16'h5A3C; // Arbitrary value
   localparam logic [15:0] OFFS [8] = '{16'h0007, 16'h000B, 16'h000D, 16'h0013, 16'h0014, 16'h001F, 16'h0018,
                                        16'h006B};
   localparam logic [15:0] MASKS [8] = '{16'h00FF, 16'h000F, 16'h03FF, 16'h0BFF, 16'h07FF, 16'h000C, 16'hFFFF,
                                         16'hBCCF};
   logic                clk;
   logic                reset;
   logic                req_valid;
   ubr_pkg::ubr_req_s   req;
   ubr_pkg::ubr_line_s  line;
   logic                resp_valid;
   logic                resp_stall;
   logic [15:0]         resp_data;
   logic [9:0]          pin_out;
   ubr_pkg::ubr_words_t cfg_words;
   logic                tx_enable;
   logic                rx_enable;
   logic [2:0]          flow_mode;
   logic [15:0]         rd;
   logic                st;
   bit                  got;
   int                  fail_count;
   int                  num_checks;
   int                  i;
   ubr_register_bank #(.REVISION_VALUE(REV)) dut (.clk(clk), .reset(reset), .req_valid(req_valid), .req(req),
      .line(line), .resp_valid(resp_valid), .resp_stall(resp_stall), .resp_data(resp_data), .cfg_words(cfg_words),
      .pin_out(pin_out), .tx_enable(tx_enable), .rx_enable(rx_enable), .flow_mode(flow_mode));
   ubr_host_model host (.clk(clk), .resp_valid(resp_valid), .resp_stall(resp_stall), .resp_data(resp_data),
      .req_valid(req_valid), .req(req));
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic report_and_stop();
      if (fail_count == 0 && num_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic req_do(input logic [7:0] rt, input logic [15:0] idx, input logic [15:0] val, input logic stl);
      host.xfer(rt, idx, val, rd, st, got);
      if (!got) begin
         fail_count++;
         report_and_stop();
      end
      check($sformatf("stall %h", idx), {15'h0, st}, {15'h0, stl});
   endtask
   task automatic rd_chk(input logic [15:0] idx, input logic [15:0] exp);
      req_do(8'hC1, idx, 16'h0000, 1'b0);
      check($sformatf("reg %h", idx), rd, exp);
   endtask
   task automatic cw(input logic [15:0] idx, input logic [15:0] val);
      host.cfg_write(idx, val, got);
      if (!got) begin
         fail_count++;
         report_and_stop();
      end
   endtask
   initial begin
      reset = 1'b1;
      line = '0;
      fail_count = 0;
      num_checks = 0;
      repeat (16) @(negedge clk);
      reset = 1'b0;
      check("enables", {14'h0, rx_enable, tx_enable}, 16'h0000);
      rd_chk(16'h0008, 16'h0013);
      // All ones exposes every reserved bit at once
      for (i = 0; i < 8; i++) begin
         cw(OFFS[i], 16'hFFFF);
         rd_chk(OFFS[i], MASKS[i]);
      end
      check("sleep drive word", cfg_words[ubr_pkg::SLOT_SLEEP_DRIVE], 16'hBCCF);
      req_do(8'h41, 16'h0000, 16'h0001, 1'b0);
      check("enables", {14'h0, rx_enable, tx_enable}, 16'h0001);
      req_do(8'h41, 16'h0000, 16'h0002, 1'b0);
      check("enables", {14'h0, rx_enable, tx_enable}, 16'h0002);
      for (i = 0; i < 6; i++) begin
         cw(16'h0006, 16'(i));
         check("flow", {13'h0, flow_mode}, (i < 5) ? 16'(i) : 16'h0004);
      end
      req_do(8'hC0, 16'h0260, 16'h0000, 1'b0);
      check("revision", rd, REV);
      req_do(8'hC1, 16'h0260, 16'h0000, 1'b1);
      req_do(8'h41, 16'h0260, 16'h1234, 1'b1);
      req_do(8'hC1, 16'h0262, 16'h0000, 1'b1);
      req_do(8'h41, 16'h0262, 16'hFFFF, 1'b1);
      req_do(8'hC0, 16'h0262, 16'h0000, 1'b0);
      check("status", rd, 16'h0000);
      req_do(8'h40, 16'h0262, 16'hFFFF, 1'b0);
      req_do(8'hC0, 16'h0262, 16'h0000, 1'b0);
      check("status", rd, 16'h3F3F);
      req_do(8'hC1, 16'h0001, 16'h0000, 1'b1);
      @(negedge clk);
      line.overrun_evt = 1'b1;
      line.parity_evt = 1'b1;
      line.break_now = 1'b1;
      @(negedge clk);
      line.overrun_evt = 1'b0;
      line.parity_evt = 1'b0;
      rd_chk(16'h0009, 16'h00E0);
      rd_chk(16'h0009, 16'h0080);
      line.break_now = 1'b0;
      line.framing_evt = 1'b1;
      line.break_evt = 1'b1;
      @(negedge clk);
      line.framing_evt = 1'b0;
      line.break_evt = 1'b0;
      rd_chk(16'h0009, 16'h0018);
      line.tx_level = 10'h2A5;
      line.rx_level = 10'h15A;
      line.pin_in = 12'hA5C;
      req_do(8'h41, 16'h0041, 16'hFFFF, 1'b0);
      rd_chk(16'h0041, 16'h02A5);
      rd_chk(16'h0044, 16'h015A);
      rd_chk(16'h0010, 16'h0A5C);
      req_do(8'h41, 16'h000E, 16'h0005, 1'b0);
      req_do(8'h41, 16'h000F, 16'h0001, 1'b0);
      check("pins", {6'h0, pin_out}, 16'h0004);
      rd_chk(16'h000E, 16'h0000);
      report_and_stop();
   end
endmodule
`default_nettype wire
